// [rtl/vfps_pkg.sv]
package vfps_pkg;

  // Device clock.
  localparam int CLK_MHZ         = 125;

  // Times as specified, then cycle counts (longest times round down).
  localparam int PERIOD_MAX_NS   = 36500;
  localparam int WATCHDOG_US     = 200;
  localparam int LINE_BLANK_MS   = 25;
  localparam int ADT_STEP_NS     = 10000;
  localparam int ON_MAX_NS       = 25000;
  localparam int LOW_DUTY_US     = 100;
  localparam int PERIOD_MAX_CYC  = PERIOD_MAX_NS * CLK_MHZ / 1000;
  localparam int WATCHDOG_CYC    = WATCHDOG_US * CLK_MHZ;
  localparam int LINE_BLANK_CYC  = LINE_BLANK_MS * CLK_MHZ * 1000;
  localparam int ADT_STEP_CYC    = ADT_STEP_NS * CLK_MHZ / 1000;
  localparam int ON_MAX_CYC      = ON_MAX_NS * CLK_MHZ / 1000;
  localparam int LOW_DUTY_CYC    = LOW_DUTY_US * CLK_MHZ;
  localparam int SOVP_STEP_CYC   = 32;

  // Control-voltage comparator ladder and foldback windows, in ladder steps.
  localparam int VCTRL_LEVELS    = 12;
  localparam int FOLD_BASE_LO    = 7;
  localparam int FOLD_BASE_HI    = 9;
  localparam int FOLD_HYST       = 1;
  localparam int ADT_LEVEL       = 2;
  localparam logic [2:0] VALLEY_MIN = 3'h1;
  localparam logic [2:0] VALLEY_MAX = 3'h6;

  // Register map.
  localparam int ADDR_W              = 4;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SOVP_BIT   = 1;
  localparam int CTRL_FOVP_LSB   = 2;
  localparam int CTRL_BOOST_BIT  = 4;
  localparam int CTRL_UNSYNC_BIT = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Fast overvoltage trip selections.
  localparam logic [1:0] FOVP_107 = 2'h0;
  localparam logic [1:0] FOVP_110 = 2'h1;
  localparam logic [1:0] FOVP_112 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ON    = 3'h1,
    ST_COUNT = 3'h3,
    ST_ADT   = 3'h2,
    ST_SYNC  = 3'h6
  } vfps_state_t;

  typedef struct packed {
    logic [VCTRL_LEVELS-1:0] vctrl_thermo;
    logic                    demag_detect_in;
    logic                    line_above;
    logic                    cs_high_imp;
    logic                    sovp_trip;
    logic                    ovp_above_release;
    logic [2:0]              fovp_trip;
    logic                    cur_limit;
    logic                    cur_150;
    logic                    therm_hot;
    logic                    therm_warm;
    logic                    out_below_boost;
  } vfps_cmp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } vfps_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } vfps_axi_rsp_t;

endpackage : vfps_pkg

// [rtl/vfps_sync.sv]
module vfps_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vfps_sync_st_t;

  vfps_sync_st_t st_q;
  vfps_sync_st_t st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule : vfps_sync

// [rtl/vfps_top.sv]
// How it works
// - Low-line only after 25 ms below threshold.
// - High load first valley; foldback adds valleys.
// - Foldback setting captured once at first enable.
// - Valley target steps one per window.
// - Extra dead time after sixth valley grows.
// - On-time starts on a demag falling edge.
// - Switching period capped at 36.5 us.
// - Window decisions use hysteresis against hopping.
// - Soft overvoltage shrinks duty gradually to zero.
// - Soft overvoltage disabled by option.
// - Soft overvoltage ends at lower release level.
// - Fast overvoltage wins, stops gate immediately.
// - Fast overvoltage resumes at release level.
// - Fast trip level chosen from three.
// - Response boost when output below 95.5 percent.
// - Steady response boost only after start-up.
// - Half-strength boost during start-up always.
// - Current limit ends the on-time.
// - Current at 150 percent forces low duty.
// - Gate held off during over-temperature.
// - Thermal restart only below lower level.
// - Three-bit valley counter, up to six.
// - Watchdog turns on after 200 us.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
module vfps_top #(
  parameter int PERIOD_MAX_CYC = vfps_pkg::PERIOD_MAX_CYC,
  parameter int WATCHDOG_CYC   = vfps_pkg::WATCHDOG_CYC,
  parameter int LINE_BLANK_CYC = vfps_pkg::LINE_BLANK_CYC,
  parameter int ON_MAX_CYC     = vfps_pkg::ON_MAX_CYC,
  parameter int LOW_DUTY_CYC   = vfps_pkg::LOW_DUTY_CYC,
  parameter int ADT_STEP_CYC   = vfps_pkg::ADT_STEP_CYC
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Register bus
  input  wire vfps_pkg::vfps_axi_req_t axi_req,
  output vfps_pkg::vfps_axi_rsp_t      axi_rsp,
  // Comparator results from the analog front end
  input  wire vfps_pkg::vfps_cmp_t     cmp_in,
  // Power stage
  output logic                         gate_drive_out,
  output logic                         response_boost_half,
  output logic                         response_boost_full,
  output logic                         low_line_range
);

  localparam int ADT_MAX_CYC = vfps_pkg::ADT_LEVEL * ADT_STEP_CYC;
  localparam int TMAX = (WATCHDOG_CYC > LOW_DUTY_CYC) ? WATCHDOG_CYC : LOW_DUTY_CYC;
  localparam int TMX2 = (TMAX > ADT_MAX_CYC) ? TMAX : ADT_MAX_CYC;
  localparam int TMX3 = (TMX2 > ON_MAX_CYC) ? TMX2 : ON_MAX_CYC;
  localparam int TW   = $clog2(((TMX3 > PERIOD_MAX_CYC) ? TMX3 : PERIOD_MAX_CYC) + 1) + 1;
  localparam int LW   = $clog2(LINE_BLANK_CYC + 1);

  if (PERIOD_MAX_CYC < 2 || WATCHDOG_CYC < 2 || LINE_BLANK_CYC < 2 || ON_MAX_CYC < 2 ||
      LOW_DUTY_CYC < 1 || ADT_STEP_CYC < 1)
  begin : g_bad_param
    $error("vfps_top: timing parameters too small");
  end

  typedef struct packed {
    vfps_pkg::vfps_state_t     st;
    logic [2:0]                target;
    logic [2:0]                valley;
    logic [TW-1:0]             per_cnt;
    logic [TW-1:0]             wd_cnt;
    logic [TW-1:0]             tmr;
    logic [TW-1:0]             on_cap;
    logic [LW-1:0]             line_cnt;
    logic                      high_line;
    logic                      fold_sel;
    logic                      fold_done;
    logic                      startup_done;
    logic                      sovp;
    logic                      fovp;
    logic                      therm;
    logic                      low_duty;
    logic                      demag_prev;
    logic                      gate;
    logic                      boost_half;
    logic                      boost_full;
    logic [31:0]               ctrl;
    logic                      aw_got;
    logic                      w_got;
    logic [vfps_pkg::ADDR_W-1:0] awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    vfps_pkg::vfps_axi_rsp_t   rsp;
  } vfps_top_st_t;

  vfps_top_st_t        q;
  vfps_top_st_t        n;
  vfps_pkg::vfps_cmp_t c;

  // Every comparator bit crosses from the analog side through two flops.
  vfps_sync #(
    .W ($bits(vfps_pkg::vfps_cmp_t))
  ) u_cmp_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (cmp_in),
    .q       (c)
  );

  always_comb
  begin
    int          lvl;
    int          base;
    int          dn_thr;
    int          adt;
    logic        fall;
    logic        en;
    logic        fovp_hit;
    logic        start_on;
    logic        period_up;
    logic [31:0] rd;
    lvl       = 0;
    base      = 0;
    dn_thr    = 0;
    adt       = 0;
    rd        = 32'h0;
    start_on  = 1'b0;
    n         = q;
    en        = q.ctrl[vfps_pkg::CTRL_EN_BIT];
    fall      = q.demag_prev & ~c.demag_detect_in;
    n.demag_prev = c.demag_detect_in;

    // Protection states.
    unique case (q.ctrl[vfps_pkg::CTRL_FOVP_LSB +: 2])
      vfps_pkg::FOVP_110: fovp_hit = c.fovp_trip[1];
      vfps_pkg::FOVP_112: fovp_hit = c.fovp_trip[2];
      default:            fovp_hit = c.fovp_trip[0];
    endcase
    if (fovp_hit)
      n.fovp = 1'b1;
    else if (!c.ovp_above_release)
      n.fovp = 1'b0;
    if (!q.ctrl[vfps_pkg::CTRL_SOVP_BIT])
      n.sovp = 1'b0;
    else if (c.sovp_trip)
      n.sovp = 1'b1;
    else if (!c.ovp_above_release)
      n.sovp = 1'b0;
    if (c.therm_hot)
      n.therm = 1'b1;
    else if (!c.therm_warm)
      n.therm = 1'b0;

    // Line range: high line at once, low line only after a full blanking time below.
    if (c.line_above)
    begin
      n.high_line = 1'b1;
      n.line_cnt  = '0;
    end
    else if (q.high_line)
    begin
      n.line_cnt = q.line_cnt + LW'(1);
      if (q.line_cnt == LW'(LINE_BLANK_CYC - 1))
        n.high_line = 1'b0;
    end

    // Foldback setting is taken when the converter is first enabled, never again.
    if (!q.fold_done && en)
    begin
      n.fold_sel  = c.cs_high_imp;
      n.fold_done = 1'b1;
    end

    // Response boost.
    if (!en)
      n.startup_done = 1'b0;
    else if (!c.out_below_boost)
      n.startup_done = 1'b1;
    n.boost_half = en & ~q.startup_done;
    n.boost_full = q.startup_done & q.ctrl[vfps_pkg::CTRL_BOOST_BIT] & c.out_below_boost;

    // Control-voltage window and extra dead time.
    for (int i = 0; i < vfps_pkg::VCTRL_LEVELS; i++)
      lvl += int'(c.vctrl_thermo[i]);
    base   = q.fold_sel ? vfps_pkg::FOLD_BASE_HI : vfps_pkg::FOLD_BASE_LO;
    dn_thr = base - (int'(q.target) - 1);
    if (q.target == vfps_pkg::VALLEY_MAX && lvl < vfps_pkg::ADT_LEVEL)
      adt = (vfps_pkg::ADT_LEVEL - lvl) * ADT_STEP_CYC;

    period_up = (q.per_cnt >= TW'(PERIOD_MAX_CYC - 1));
    n.per_cnt = period_up ? q.per_cnt : q.per_cnt + TW'(1);

    unique case (q.st)
      vfps_pkg::ST_IDLE:
      begin
        if (q.tmr != '0)
          n.tmr = q.tmr - TW'(1);
        if (!q.sovp)
          n.on_cap = TW'(ON_MAX_CYC);
        n.low_duty = (q.tmr != '0);
        if (en && q.tmr == '0 && n.on_cap != '0)
          start_on = 1'b1;
      end
      vfps_pkg::ST_ON:
      begin
        n.tmr = q.tmr + TW'(1);
        // The valley target only moves here, so it is locked while valleys are counted.
        if (q.target < vfps_pkg::VALLEY_MAX && lvl < dn_thr)
          n.target = q.target + 3'h1;
        else if (q.target > vfps_pkg::VALLEY_MIN && lvl >= dn_thr + 1 + vfps_pkg::FOLD_HYST)
          n.target = q.target - 3'h1;
        if (c.cur_limit || q.tmr >= q.on_cap - TW'(1))
        begin
          n.gate   = 1'b0;
          n.valley = 3'h0;
          n.wd_cnt = '0;
          n.st     = vfps_pkg::ST_COUNT;
          if (q.sovp)
            n.on_cap = (q.on_cap > TW'(vfps_pkg::SOVP_STEP_CYC)) ?
                       q.on_cap - TW'(vfps_pkg::SOVP_STEP_CYC) : '0;
          else
            n.on_cap = TW'(ON_MAX_CYC);
          if (c.cur_150 || n.on_cap == '0)
          begin
            n.st  = vfps_pkg::ST_IDLE;
            n.tmr = c.cur_150 ? TW'(LOW_DUTY_CYC) : '0;
          end
        end
      end
      vfps_pkg::ST_COUNT:
      begin
        n.wd_cnt = q.wd_cnt + TW'(1);
        if (fall)
        begin
          n.valley = q.valley + 3'h1;
          n.wd_cnt = '0;
          if (q.valley + 3'h1 >= q.target)
          begin
            if (adt > 0)
            begin
              n.st  = vfps_pkg::ST_ADT;
              n.tmr = TW'(adt);
            end
            else
              start_on = 1'b1;
          end
        end
        if (q.wd_cnt >= TW'(WATCHDOG_CYC - 1))
          start_on = 1'b1;
      end
      vfps_pkg::ST_ADT:
      begin
        n.tmr = q.tmr - TW'(1);
        if (q.tmr <= TW'(1))
        begin
          if (q.ctrl[vfps_pkg::CTRL_UNSYNC_BIT])
            start_on = 1'b1;
          else
            n.st = vfps_pkg::ST_SYNC;
        end
      end
      vfps_pkg::ST_SYNC:
      begin
        if (fall)
          start_on = 1'b1;
      end
      default:
        n.st = vfps_pkg::ST_IDLE;
    endcase

    if (q.st != vfps_pkg::ST_IDLE && q.st != vfps_pkg::ST_ON && period_up)
      start_on = 1'b1;
    if (start_on && n.on_cap != '0)
    begin
      n.st      = vfps_pkg::ST_ON;
      n.gate    = 1'b1;
      n.tmr     = '0;
      n.per_cnt = '0;
    end
    else if (start_on)
      n.st = vfps_pkg::ST_IDLE;

    // Protections override the sequencing on the very next edge.
    if (n.fovp || n.therm || c.cur_limit || !en)
    begin
      n.gate = 1'b0;
      if (n.fovp || n.therm || !en)
      begin
        n.st  = vfps_pkg::ST_IDLE;
        n.tmr = (q.st == vfps_pkg::ST_IDLE) ? n.tmr : '0;
      end
    end

    // AXI4-Lite slave: one write and one read at a time.
    if (axi_req.awvalid && q.rsp.awready)
    begin
      n.aw_got      = 1'b1;
      n.awaddr      = axi_req.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && q.rsp.wready)
    begin
      n.w_got      = 1'b1;
      n.wdata      = axi_req.wdata;
      n.wstrb      = axi_req.wstrb;
      n.rsp.wready = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.rsp.bvalid)
    begin
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = vfps_pkg::RESP_OKAY;
      if (q.awaddr == vfps_pkg::ADDR_CTRL)
      begin
        for (int b = 0; b < 4; b++)
          if (q.wstrb[b])
            n.ctrl[8*b +: 8] = q.wdata[8*b +: 8];
      end
      else if (q.awaddr != vfps_pkg::ADDR_STATUS)
        n.rsp.bresp = vfps_pkg::RESP_SLVERR;
    end
    if (q.rsp.bvalid && axi_req.bready)
    begin
      n.rsp.bvalid  = 1'b0;
      n.aw_got      = 1'b0;
      n.w_got       = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready  = 1'b1;
    end
    rd = {18'h0, q.low_duty, q.therm, q.fovp, q.sovp, q.high_line, q.startup_done,
          q.fold_sel, q.target, 3'(q.st)};
    if (axi_req.arvalid && q.rsp.arready)
    begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid  = 1'b1;
      n.rsp.rresp   = vfps_pkg::RESP_OKAY;
      n.rsp.rdata   = 32'h0;
      if (axi_req.araddr == vfps_pkg::ADDR_CTRL)
        n.rsp.rdata = q.ctrl;
      else if (axi_req.araddr == vfps_pkg::ADDR_STATUS)
        n.rsp.rdata = rd;
      else
        n.rsp.rresp = vfps_pkg::RESP_SLVERR;
    end
    if (q.rsp.rvalid && axi_req.rready)
    begin
      n.rsp.rvalid  = 1'b0;
      n.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q             <= '0;
      q.st          <= vfps_pkg::ST_IDLE;
      q.target      <= vfps_pkg::VALLEY_MIN;
      q.on_cap      <= TW'(ON_MAX_CYC);
      q.high_line   <= 1'b1;
      q.ctrl        <= vfps_pkg::CTRL_RESET;
      q.rsp.awready <= 1'b1;
      q.rsp.wready  <= 1'b1;
      q.rsp.arready <= 1'b1;
    end
    else
      q <= n;
  end

  assign axi_rsp             = q.rsp;
  assign gate_drive_out      = q.gate;
  assign response_boost_half = q.boost_half;
  assign response_boost_full = q.boost_full;
  assign low_line_range      = ~q.high_line;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wait_valley;
    q.st == vfps_pkg::ST_SYNC && q.demag_prev && !c.demag_detect_in;
  endsequence

  sequence s_clear_path;
    !n.fovp && !n.therm && !c.cur_limit && q.ctrl[vfps_pkg::CTRL_EN_BIT] && q.on_cap != '0;
  endsequence

  chk_cur_limit_off: assert property (c.cur_limit |=> !gate_drive_out)
    else $error("gate high after current limit");
  chk_therm_gate: assert property (q.therm |-> !gate_drive_out)
    else $error("gate high during thermal shutdown");
  chk_fovp_gate: assert property ($rose(q.fovp) |-> !gate_drive_out)
    else $error("gate high on fast overvoltage");
  chk_valley_range: assert property (q.target >= vfps_pkg::VALLEY_MIN && q.target <= vfps_pkg::VALLEY_MAX)
    else $error("valley target out of range");
  chk_target_step: assert property ($changed(q.target) |->
      (q.target == $past(q.target) + 3'h1 || q.target == $past(q.target) - 3'h1) && $past(q.st) == vfps_pkg::ST_ON)
    else $error("valley target jumped");
  chk_period_cap: assert property (q.st != vfps_pkg::ST_ON |-> q.per_cnt <= TW'(PERIOD_MAX_CYC))
    else $error("switching period exceeded");
  chk_valley_turn_on: assert property (s_wait_valley ##0 s_clear_path |=> gate_drive_out && q.st == vfps_pkg::ST_ON)
    else $error("no turn-on at valley");
  chk_line_blank: assert property ($fell(q.high_line) |-> $past(q.line_cnt) == LW'(LINE_BLANK_CYC - 1))
    else $error("low line without full blanking");
  chk_startup_boost: assert property (q.ctrl[vfps_pkg::CTRL_EN_BIT] && !q.startup_done |=> response_boost_half)
    else $error("no start-up boost");
  chk_sovp_option: assert property (!q.ctrl[vfps_pkg::CTRL_SOVP_BIT] |=> !q.sovp)
    else $error("soft overvoltage active while disabled");

endmodule : vfps_top

// [tb/vfps_power_model.sv]
module vfps_power_model (
  // Clock
  input  wire logic       aclk,
  // Gate and knobs
  input  wire logic       gate_drive_out,
  input  wire logic       ring_en,
  input  wire logic [7:0] ring_half,
  // Comparator levels
  output logic            demag_detect_in,
  output logic            cur_limit
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt_q  = 8'h00;
  logic       gate_q = 1'b0;

  // The switch current ramps, so the limit trips a few cycles into each on-time.
  // After turn-off the drain rings; with ringing off, demag stays high and no valley ever comes.
  always @(posedge aclk)
  begin
    gate_q <= gate_drive_out;
    cnt_q <= (gate_drive_out !== gate_q) ? 8'h00 : cnt_q + 8'h01;
    cur_limit <= gate_drive_out && (cnt_q >= 8'h05);
    demag_detect_in <= gate_drive_out || !ring_en || (cnt_q < 8'h0a) || ((cnt_q / ring_half) % 2 == 0);
  end
endmodule : vfps_power_model

// [tb/valley_foldback_protection_sequencer_test.sv]
module valley_foldback_protection_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    aclk      = 1'b0;
  logic                    aresetn   = 1'b0;
  vfps_pkg::vfps_axi_req_t axi_req   = '0;
  vfps_pkg::vfps_axi_rsp_t axi_rsp;
  vfps_pkg::vfps_cmp_t     cmp       = '0;
  vfps_pkg::vfps_cmp_t     cmp_in;
  logic                    gate_drive_out;
  logic                    boost_half;
  logic                    boost_full;
  logic                    low_line_range;
  logic                    demag;
  logic                    cur_lim;
  logic                    ring_en   = 1'b1;
  logic [7:0]              ring_half = 8'h03;
  logic [31:0]             rd;
  logic [1:0]              rsp;
  int                      n_cyc;
  int                      errors    = 0;
  int                      check_count = 0;

  always_comb
  begin
    cmp_in = cmp;
    cmp_in.demag_detect_in = demag;
    cmp_in.cur_limit = cur_lim;
  end

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  vfps_top #(.PERIOD_MAX_CYC(100), .WATCHDOG_CYC(60), .LINE_BLANK_CYC(50), .ON_MAX_CYC(30),
             .LOW_DUTY_CYC(20), .ADT_STEP_CYC(10)) uut (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .axi_req             (axi_req),
    .axi_rsp             (axi_rsp),
    .cmp_in              (cmp_in),
    .gate_drive_out      (gate_drive_out),
    .response_boost_half (boost_half),
    .response_boost_full (boost_full),
    .low_line_range      (low_line_range)
  );

  vfps_power_model pwr (
    .aclk            (aclk),
    .gate_drive_out  (gate_drive_out),
    .ring_en         (ring_en),
    .ring_half       (ring_half),
    .demag_detect_in (demag),
    .cur_limit       (cur_lim)
  );

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // The bus task holds each valid until its ready is sampled high, and bready or rready until the response is valid.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.araddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= wr;
    axi_req.wvalid <= wr;
    axi_req.bready <= wr;
    axi_req.arvalid <= !wr;
    axi_req.rready <= !wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
      if (axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if ((wr && axi_rsp.bvalid) || (!wr && axi_rsp.rvalid))
        break;
    end
    axi_req.bready <= 1'b0;
    axi_req.rready <= 1'b0;
    rd = axi_rsp.rdata;
    rsp = wr ? axi_rsp.bresp : axi_rsp.rresp;
    #1;
    chk(n < 50, "bus timeout");
    if (n == 50)
      end_sim();
  endtask : bus

  task automatic gw(input logic v);
    n_cyc = 0;
    while (gate_drive_out !== v && n_cyc < 3000)
    begin
      @(posedge aclk);
      #1;
      n_cyc++;
    end
    if (n_cyc == 3000)
    begin
      chk(1'b0, "gate wait timeout");
      end_sim();
    end
  endtask : gw

  task automatic hold_low(input int c);
    logic ok;
    ok = 1'b1;
    repeat (c)
    begin
      @(posedge aclk);
      #1;
      if (gate_drive_out !== 1'b0)
        ok = 1'b0;
    end
    chk(ok, "gate switched while blocked");
  endtask : hold_low

  // Rise-to-rise switching period in cycles.
  task automatic period(output int p);
    gw(1'b1);
    gw(1'b0);
    p = n_cyc;
    gw(1'b1);
    p = p + n_cyc;
  endtask : period

  task automatic t_reset;
    chk(gate_drive_out === 1'b0 && boost_half === 1'b0 && low_line_range === 1'b0, "reset outputs");
    bus(1'b0, vfps_pkg::ADDR_CTRL, 32'h0);
    chk(rd === vfps_pkg::CTRL_RESET && rsp === vfps_pkg::RESP_OKAY, "ctrl reset");
    bus(1'b0, 4'h8, 32'h0);
    chk(rsp === vfps_pkg::RESP_SLVERR, "unmapped read");
  endtask : t_reset

  task automatic t_start;
    bus(1'b1, vfps_pkg::ADDR_CTRL, 32'h0000_0003);
    gw(1'b1);
    chk(n_cyc <= 4, "no turn-on");
    chk(boost_half === 1'b1 && boost_full === 1'b0, "start-up boost");
    gw(1'b0);
    chk(n_cyc <= 12, "current limit");
    gw(1'b1);
    chk(n_cyc >= 12 && n_cyc <= 16, "first valley turn-on");
    @(posedge aclk);
    cmp.out_below_boost <= 1'b0;
    repeat (5) @(posedge aclk);
    #1;
    chk(boost_half === 1'b0, "half boost after start-up");
    bus(1'b1, vfps_pkg::ADDR_CTRL, 32'h0000_0013);
    @(posedge aclk);
    cmp.out_below_boost <= 1'b1;
    repeat (5) @(posedge aclk);
    #1;
    chk(boost_full === 1'b1, "steady boost");
    @(posedge aclk);
    cmp.out_below_boost <= 1'b0;
  endtask : t_start

  task automatic t_valley;
    int lv[5] = '{6, 7, 8, 1, 0};
    logic [2:0] ex[5] = '{3'h2, 3'h2, 3'h1, 3'h6, 3'h6};
    int p1;
    int p0;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge aclk);
      cmp.vctrl_thermo <= 12'((13'h1 << lv[i]) - 13'h1);
      repeat (800) @(posedge aclk);
      bus(1'b0, vfps_pkg::ADDR_STATUS, 32'h0);
      chk(rd[5:3] === ex[i], "valley target");
      if (i == 3)
        period(p1);
    end
    period(p0);
    chk(p0 > p1 + 5, "extra dead time growth");
    ring_half <= 8'h0c;
    period(p0);
    period(p0);
    chk(p0 >= 98 && p0 <= 101, "period cap");
    @(posedge aclk);
    cmp.vctrl_thermo <= 12'hfff;
    ring_half <= 8'h03;
    repeat (800) @(posedge aclk);
    ring_en <= 1'b0;
    gw(1'b1);
    gw(1'b0);
    gw(1'b1);
    chk(n_cyc >= 58 && n_cyc <= 63, "watchdog turn-on");
    ring_en <= 1'b1;
  endtask : t_valley

  task automatic t_fault(input int k);
    gw(1'b1);
    @(posedge aclk);
    if (k == 0)
      cmp.fovp_trip <= 3'h1;
    else
      {cmp.therm_hot, cmp.therm_warm} <= 2'h3;
    repeat (3) @(posedge aclk);
    #1;
    chk(gate_drive_out === 1'b0, "fault gate off");
    hold_low(60);
    @(posedge aclk);
    cmp.fovp_trip <= 3'h0;
    cmp.therm_hot <= 1'b0;
    if (k == 1)
      hold_low(60);
    @(posedge aclk);
    cmp.therm_warm <= 1'b0;
    gw(1'b1);
    chk(n_cyc <= 150, "resume after fault");
  endtask : t_fault

  task automatic t_soft;
    @(posedge aclk);
    {cmp.sovp_trip, cmp.ovp_above_release} <= 2'h3;
    repeat (400) @(posedge aclk);
    hold_low(150);
    @(posedge aclk);
    cmp.sovp_trip <= 1'b0;
    hold_low(150);
    @(posedge aclk);
    cmp.ovp_above_release <= 1'b0;
    gw(1'b1);
    chk(n_cyc <= 200, "soft release");
    bus(1'b1, vfps_pkg::ADDR_CTRL, 32'h0000_0001);
    @(posedge aclk);
    cmp.sovp_trip <= 1'b1;
    repeat (400) @(posedge aclk);
    gw(1'b1);
    gw(1'b0);
    gw(1'b1);
    chk(n_cyc <= 150, "soft handling disabled");
  endtask : t_soft

  // When the current limit ends the on-time, the 150 percent current flag sends it into a fixed holdoff.
  task automatic t_lowduty;
    gw(1'b1);
    @(posedge aclk);
    cmp.cur_150 <= 1'b1;
    gw(1'b0);
    repeat (4) @(posedge aclk);
    cmp.cur_150 <= 1'b0;
    bus(1'b0, vfps_pkg::ADDR_STATUS, 32'h0);
    chk(rd[12] === 1'b1, "low duty holdoff flag");
    gw(1'b1);
    chk(n_cyc >= 8, "low duty holdoff length");
  endtask : t_lowduty

  task automatic t_line;
    @(posedge aclk);
    cmp.line_above <= 1'b0;
    n_cyc = 0;
    while (low_line_range !== 1'b1 && n_cyc < 200)
    begin
      @(posedge aclk);
      #1;
      n_cyc++;
    end
    chk(n_cyc >= 50 && n_cyc <= 56, "line range blanking");
  endtask : t_line

  initial
  begin
    cmp.vctrl_thermo = 12'hfff;
    cmp.line_above = 1'b1;
    cmp.out_below_boost = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    t_reset();
    t_start();
    t_valley();
    t_fault(0);
    t_fault(1);
    t_soft();
    t_lowduty();
    t_line();
    end_sim();
  end
endmodule : valley_foldback_protection_sequencer_test
